// ===== hdl/pcfg_pkg.sv
// Constants, register map and carrier types of the pin configuration block.
// Assumes a 16-bit register port on the system clock, index addressing.
// Function
// - Third port analog register has writable select bits 14:13 and 4.
// - Select bit at 1 puts the pin in analog mode, port read disabled.
// - Select bit at 0 puts the pin in digital mode, port read enabled.
// - Smaller pin count variant lacks the third port bit 4 select.
// - Fourth port analog register implements writable select bits 7:6.
// - Fourth port register bit 13 is reserved and always reads 1.
// - Unimplemented bits read 0 and ignore writes.
// - Forty remap registers: 24 input selects, 16 output assignments.
// - Remap register writes are ignored while the config lock bit is 1.
// - First input remap bits 5:0 select the output compare trigger 1 pin.
// - Output remap fields route a numbered peripheral output to the pin.
package pcfg_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 6;
  localparam int NUM_IN_REGS = 24;
  localparam int NUM_OUT_REGS = 16;
  localparam int NUM_REMAP_REGS = 40;
  localparam int FLD_LO_LSB = 0;
  localparam int FLD_HI_LSB = 8;
  localparam int LOCK_POS = 6;

  // Register indices
  localparam logic [ADDR_W-1:0] OFF_ANA_C = 7'h00;
  localparam logic [ADDR_W-1:0] OFF_ANA_D = 7'h01;
  localparam logic [ADDR_W-1:0] OFF_LOCK = 7'h02;
  localparam logic [ADDR_W-1:0] OFF_IN_BASE = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_OUT_BASE = 7'h30;

  // Field layouts and reset values
  localparam logic [DATA_W-1:0] ANA_C_MASK = 16'h6010;
  localparam logic [DATA_W-1:0] ANA_C4_BIT = 16'h0010;
  localparam logic [DATA_W-1:0] ANA_D_MASK = 16'h00c0;
  localparam logic [DATA_W-1:0] ANA_D_RSVD = 16'h2000;
  localparam logic [DATA_W-1:0] IN_MASK = 16'h3f3f;
  localparam logic [DATA_W-1:0] IN_RST = 16'h3f3f;
  localparam logic [DATA_W-1:0] OUT_MASK = 16'h3f3f;
  localparam logic [DATA_W-1:0] OUT_RST = 16'h0000;
  localparam logic LOCK_RST = 1'b0;

  // Positions in the peripheral input vector
  localparam int PIN_OC_TRIG1 = 0;
  localparam int PIN_EXT_INT1 = 1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcfg_req_type;

endpackage

// ===== hdl/pcfg_in_sel.sv
// Picks one remappable pin as the source of a peripheral input.
// Assumes the pin vector is already synchronised to the caller's clock.
`timescale 1ns/100ps
module pcfg_in_sel #(
  parameter int N_PINS = 48,
  parameter int SEL_W = 6
) (
  input wire logic [N_PINS-1:0] i_pins,
  input wire logic [SEL_W-1:0] i_sel,
  output logic o_val
);
  // Selections past the last pin leave the input low
  always_comb begin
    o_val = 1'b0;
    for (int k = 0; k < N_PINS; k++) begin
      if (int'(i_sel) == k) begin
        o_val = i_pins[k];
      end
    end
  end
endmodule

// ===== hdl/pcfg_out_sel.sv
// Routes one numbered peripheral output onto a remappable pin.
// Assumes number 0 means no peripheral; the pin then stays with its port.
`timescale 1ns/100ps
module pcfg_out_sel #(
  parameter int N_FUNCS = 32,
  parameter int SEL_W = 6
) (
  input wire logic [N_FUNCS-1:0] i_funcs,
  input wire logic [SEL_W-1:0] i_sel,
  output logic o_val,
  output logic o_en
);
  always_comb begin
    o_val = 1'b0;
    o_en = 1'b0;
    for (int k = 1; k < N_FUNCS; k++) begin
      if (int'(i_sel) == k) begin
        o_val = i_funcs[k];
        o_en = 1'b1;
      end
    end
  end
endmodule

// ===== hdl/pcfg_top.sv
// Analog select and peripheral remap registers with pin routing.
// Assumes a one-cycle register port master and asynchronous pin inputs.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module pcfg_top #(
  parameter bit BIG_PKG = 1'b1,
  parameter int NUM_RP_IN = 48,
  parameter int NUM_PERIPH_OUT = 32
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire pcfg_pkg::pcfg_req_type i_req,
  output logic [pcfg_pkg::DATA_W-1:0] o_rdata,
  input wire logic [15:0] i_third_io_port_pins,
  input wire logic [15:0] i_fourth_io_port_pins,
  output logic [15:0] o_third_io_port_read,
  output logic [15:0] o_fourth_io_port_read,
  output logic [15:0] o_third_io_port_analog,
  output logic [15:0] o_fourth_io_port_analog,
  input wire logic [NUM_RP_IN-1:0] i_rp_pins,
  output logic [2*pcfg_pkg::NUM_IN_REGS-1:0] o_periph_in,
  input wire logic [NUM_PERIPH_OUT-1:0] i_periph_out,
  output logic [2*pcfg_pkg::NUM_OUT_REGS-1:0] o_rp_out,
  output logic [2*pcfg_pkg::NUM_OUT_REGS-1:0] o_rp_out_en,
  output logic o_pin_config_lock
);
  import pcfg_pkg::*;

  localparam int N_PIN_IN = 2 * NUM_IN_REGS;
  localparam int N_PIN_OUT = 2 * NUM_OUT_REGS;
  localparam logic [DATA_W-1:0] C_MASK =
    BIG_PKG ? ANA_C_MASK : (ANA_C_MASK & ~ANA_C4_BIT);

  if (NUM_RP_IN < 1 || NUM_RP_IN > 64) begin : g_chk_rp
    $error("NUM_RP_IN must lie in 1..64");
  end
  if (NUM_PERIPH_OUT < 2 || NUM_PERIPH_OUT > 64) begin : g_chk_po
    $error("NUM_PERIPH_OUT must lie in 2..64");
  end
  if (NUM_IN_REGS + NUM_OUT_REGS != NUM_REMAP_REGS) begin : g_chk_n
    $error("Remap register count mismatch");
  end

  typedef struct packed {
    logic [DATA_W-1:0] ana_c;
    logic [DATA_W-1:0] ana_d;
    logic lock;
    logic [NUM_IN_REGS-1:0][DATA_W-1:0] in_remap;
    logic [NUM_OUT_REGS-1:0][DATA_W-1:0] out_remap;
    logic [DATA_W-1:0] rdata;
    logic [15:0] pc_s1;
    logic [15:0] pc_s2;
    logic [15:0] pd_s1;
    logic [15:0] pd_s2;
    logic [NUM_RP_IN-1:0] rp_s1;
    logic [NUM_RP_IN-1:0] rp_s2;
    logic [15:0] third_io_port_rd;
    logic [15:0] fourth_io_port_rd;
    logic [N_PIN_IN-1:0] periph_in;
    logic [N_PIN_OUT-1:0] rp_out;
    logic [N_PIN_OUT-1:0] rp_en;
  } pcfg_top_state_type;

  pcfg_top_state_type r;
  pcfg_top_state_type r_nxt;

  logic [N_PIN_IN-1:0] in_val;
  logic [N_PIN_OUT-1:0] out_val;
  logic [N_PIN_OUT-1:0] out_en;
  logic in_hit;
  logic out_hit;
  logic [4:0] in_idx;
  logic [3:0] out_idx;

  // One selector per peripheral input field, fed by the synced pins
  for (genvar g = 0; g < N_PIN_IN; g++) begin : g_in
    pcfg_in_sel #(
      .N_PINS(NUM_RP_IN),
      .SEL_W(FIELD_W)
    ) u_in_sel (
      .i_pins(r.rp_s2),
      .i_sel(r.in_remap[g/2][(g%2)*FLD_HI_LSB +: FIELD_W]),
      .o_val(in_val[g])
    );
  end

  // One router per remappable output pin
  for (genvar g = 0; g < N_PIN_OUT; g++) begin : g_out
    pcfg_out_sel #(
      .N_FUNCS(NUM_PERIPH_OUT),
      .SEL_W(FIELD_W)
    ) u_out_sel (
      .i_funcs(i_periph_out),
      .i_sel(r.out_remap[g/2][(g%2)*FLD_HI_LSB +: FIELD_W]),
      .o_val(out_val[g]),
      .o_en(out_en[g])
    );
  end

  always_comb begin
    in_idx = 5'(i_req.addr - OFF_IN_BASE);
    out_idx = 4'(i_req.addr - OFF_OUT_BASE);
    in_hit = (i_req.addr >= OFF_IN_BASE) &&
      (i_req.addr < OFF_IN_BASE + 7'(NUM_IN_REGS));
    out_hit = (i_req.addr >= OFF_OUT_BASE) &&
      (i_req.addr < OFF_OUT_BASE + 7'(NUM_OUT_REGS));
  end

  always_comb begin
    r_nxt = r;
    r_nxt.rdata = '0;
    if (i_req.wr) begin
      case (i_req.addr)
        OFF_ANA_C: begin
          r_nxt.ana_c = i_req.wdata & C_MASK;
        end
        OFF_ANA_D: begin
          r_nxt.ana_d = i_req.wdata & ANA_D_MASK;
        end
        OFF_LOCK: begin
          r_nxt.lock = i_req.wdata[LOCK_POS];
        end
        default: begin
          // Remap contents only change while unlocked
          if (!r.lock && in_hit) begin
            r_nxt.in_remap[in_idx] = i_req.wdata & IN_MASK;
          end
          if (!r.lock && out_hit) begin
            r_nxt.out_remap[out_idx] = i_req.wdata & OUT_MASK;
          end
        end
      endcase
    end
    if (i_req.rd) begin
      case (i_req.addr)
        OFF_ANA_C: begin
          r_nxt.rdata = r.ana_c;
        end
        OFF_ANA_D: begin
          r_nxt.rdata = r.ana_d | ANA_D_RSVD;
        end
        OFF_LOCK: begin
          r_nxt.rdata = 16'(r.lock) << LOCK_POS;
        end
        default: begin
          if (in_hit) begin
            r_nxt.rdata = r.in_remap[in_idx];
          end else if (out_hit) begin
            r_nxt.rdata = r.out_remap[out_idx];
          end else begin
            r_nxt.rdata = '0;
          end
        end
      endcase
    end
    r_nxt.pc_s1 = i_third_io_port_pins;
    r_nxt.pc_s2 = r.pc_s1;
    r_nxt.pd_s1 = i_fourth_io_port_pins;
    r_nxt.pd_s2 = r.pd_s1;
    r_nxt.rp_s1 = i_rp_pins;
    r_nxt.rp_s2 = r.rp_s1;
    // Analog pins read as zero on the port
    r_nxt.third_io_port_rd = r.pc_s2 & ~r.ana_c;
    r_nxt.fourth_io_port_rd = r.pd_s2 & ~r.ana_d;
    r_nxt.periph_in = in_val;
    r_nxt.rp_out = out_val & out_en;
    r_nxt.rp_en = out_en;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
      r.ana_c <= C_MASK;
      r.ana_d <= ANA_D_MASK;
      r.in_remap <= {NUM_IN_REGS{IN_RST}};
      r.out_remap <= {NUM_OUT_REGS{OUT_RST}};
      r.lock <= LOCK_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_rdata = r.rdata;
  assign o_third_io_port_read = r.third_io_port_rd;
  assign o_fourth_io_port_read = r.fourth_io_port_rd;
  assign o_third_io_port_analog = r.ana_c;
  assign o_fourth_io_port_analog = r.ana_d;
  assign o_periph_in = r.periph_in;
  assign o_rp_out = r.rp_out;
  assign o_rp_out_en = r.rp_en;
  assign o_pin_config_lock = r.lock;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  property p_ana_c_write;
    i_req.wr && i_req.addr == OFF_ANA_C ##1 i_req.rd && i_req.addr == OFF_ANA_C
      |=> o_rdata == ($past(i_req.wdata, 2) & C_MASK);
  endproperty
  a_ana_c_write: assert property (p_ana_c_write)
    else $error("third port analog select readback wrong");

  property p_analog_blocks_read;
    ##1 (o_third_io_port_read & $past(r.ana_c)) == 16'h0000 &&
      (o_fourth_io_port_read & $past(r.ana_d)) == 16'h0000;
  endproperty
  a_analog_blocks_read: assert property (p_analog_blocks_read)
    else $error("analog pin leaked onto port read");

  property p_digital_reads;
    ##3 o_fourth_io_port_read == ($past(i_fourth_io_port_pins, 3) & ~$past(r.ana_d))
      || $past(r.ana_d) != $past(r.ana_d, 3);
  endproperty
  a_digital_reads: assert property (p_digital_reads)
    else $error("digital pin not passed to port read after sync");

  property p_small_pkg_c4;
    !BIG_PKG |-> o_third_io_port_analog[4] == 1'b0;
  endproperty
  a_small_pkg_c4: assert property (p_small_pkg_c4)
    else $error("bit 4 select present on small package");

  property p_ana_d_read;
    i_req.rd && i_req.addr == OFF_ANA_D |=> o_rdata[13] == 1'b1 &&
      (o_rdata & ~(ANA_D_MASK | ANA_D_RSVD)) == 16'h0000 &&
      o_rdata[7:6] == $past(r.ana_d[7:6]);
  endproperty
  a_ana_d_read: assert property (p_ana_d_read)
    else $error("fourth port analog select readback wrong");

  property p_unmapped_zero;
    i_req.rd && !in_hit && !out_hit && i_req.addr != OFF_ANA_C &&
      i_req.addr != OFF_ANA_D && i_req.addr != OFF_LOCK
      |=> o_rdata == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_remap_write_lands;
    i_req.wr && !o_pin_config_lock && out_hit &&
      i_req.addr == OFF_OUT_BASE + 7'(NUM_OUT_REGS - 1)
      |=> r.out_remap[NUM_OUT_REGS-1] == ($past(i_req.wdata) & OUT_MASK);
  endproperty
  a_remap_write_lands: assert property (p_remap_write_lands)
    else $error("last output remap register not written");

  property p_locked_ignored;
    o_pin_config_lock && i_req.wr && (in_hit || out_hit)
      |=> $stable(r.in_remap) && $stable(r.out_remap);
  endproperty
  a_locked_ignored: assert property (p_locked_ignored)
    else $error("remap changed while locked");

  property p_oc_trig_route;
    $stable(r.in_remap[0]) && $stable(r.rp_s2) &&
      r.in_remap[0][FLD_LO_LSB +: FIELD_W] == 6'h00
      |=> o_periph_in[PIN_OC_TRIG1] == $past(r.rp_s2[0]);
  endproperty
  a_oc_trig_route: assert property (p_oc_trig_route)
    else $error("trigger 1 input not taken from pin 0");

  property p_int1_unmapped;
    r.in_remap[0][FLD_HI_LSB +: FIELD_W] == 6'h3f
      |=> o_periph_in[PIN_EXT_INT1] == 1'b0;
  endproperty
  a_int1_unmapped: assert property (p_int1_unmapped)
    else $error("interrupt 1 input driven with no pin selected");

  property p_out_route;
    r.out_remap[0][FLD_LO_LSB +: FIELD_W] == 6'h00
      |=> o_rp_out_en[0] == 1'b0 && o_rp_out[0] == 1'b0;
  endproperty
  a_out_route: assert property (p_out_route)
    else $error("pin 0 driven with no peripheral assigned");

  property p_out_func1;
    r.out_remap[0][FLD_HI_LSB +: FIELD_W] == 6'h01
      |=> o_rp_out_en[1] && o_rp_out[1] == $past(i_periph_out[1]);
  endproperty
  a_out_func1: assert property (p_out_func1)
    else $error("peripheral output 1 not routed to pin 1");

  property p_ana_c_lands;
    i_req.wr && i_req.addr == OFF_ANA_C
      |=> o_third_io_port_analog == ($past(i_req.wdata) & C_MASK);
  endproperty
  a_ana_c_lands: assert property (p_ana_c_lands)
    else $error("third port analog select not written");

  property p_ana_d_lands;
    i_req.wr && i_req.addr == OFF_ANA_D
      |=> o_fourth_io_port_analog == ($past(i_req.wdata) & ANA_D_MASK);
  endproperty
  a_ana_d_lands: assert property (p_ana_d_lands)
    else $error("fourth port analog select not written");

  property p_third_io_port_digital;
    ##3 o_third_io_port_read ==
      ($past(i_third_io_port_pins, 3) & ~$past(r.ana_c));
  endproperty
  a_third_io_port_digital: assert property (p_third_io_port_digital)
    else $error("third port read does not follow pins and mode");

  property p_remap_read_masked;
    i_req.rd && (in_hit || out_hit)
      |=> (o_rdata & ~(IN_MASK | OUT_MASK)) == 16'h0000;
  endproperty
  a_remap_read_masked: assert property (p_remap_read_masked)
    else $error("unimplemented remap bits read back nonzero");

  property p_in_remap_lands;
    i_req.wr && !o_pin_config_lock && i_req.addr == OFF_IN_BASE
      |=> r.in_remap[0] == ($past(i_req.wdata) & IN_MASK);
  endproperty
  a_in_remap_lands: assert property (p_in_remap_lands)
    else $error("first input remap register not written");

  property p_int1_route;
    r.in_remap[0][FLD_HI_LSB +: FIELD_W] == 6'h01
      |=> o_periph_in[PIN_EXT_INT1] == $past(r.rp_s2[1]);
  endproperty
  a_int1_route: assert property (p_int1_route)
    else $error("interrupt 1 input not taken from pin 1");

  property p_rdata_idle;
    !i_req.rd
      |=> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read strobe");

  property p_lock_write;
    i_req.wr && i_req.addr == OFF_LOCK
      |=> o_pin_config_lock == $past(i_req.wdata[LOCK_POS]);
  endproperty
  a_lock_write: assert property (p_lock_write)
    else $error("configuration lock bit not written");

  property p_out_unassigned;
    int'(r.out_remap[0][FLD_LO_LSB +: FIELD_W]) >= NUM_PERIPH_OUT
      |=> !o_rp_out_en[0] && !o_rp_out[0];
  endproperty
  a_out_unassigned: assert property (p_out_unassigned)
    else $error("pin 0 driven by a peripheral number out of range");

endmodule

// ===== verif/pcfg_top_tb_top.sv
// Self-checking bench of the pin configuration block, with a register model.
// Assumes the one-cycle register port and index map of pcfg_pkg.
`timescale 1ns/100ps
module pcfg_top_tb_top;
  import pcfg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  pcfg_req_type i_req = '0;
  logic [15:0] o_rdata, pc_rd, pd_rd, pc_an, pd_an, s_an;
  logic [15:0] pc_pins = 16'h0000;
  logic [15:0] pd_pins = 16'h0000;
  logic [47:0] rp_pins = 48'h0, p_in;
  logic [31:0] p_out = 32'h0, rp_out, rp_en;
  logic lock;
  logic [15:0] mem [128];
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 i_mclk = ~i_mclk;

  pcfg_top i_pcfg_top (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_req(i_req), .o_rdata(o_rdata), .i_third_io_port_pins(pc_pins),
    .i_fourth_io_port_pins(pd_pins), .o_third_io_port_read(pc_rd), .o_fourth_io_port_read(pd_rd),
    .o_third_io_port_analog(pc_an), .o_fourth_io_port_analog(pd_an), .i_rp_pins(rp_pins),
    .o_periph_in(p_in), .i_periph_out(p_out), .o_rp_out(rp_out),
    .o_rp_out_en(rp_en), .o_pin_config_lock(lock));

  // Smaller pin count variant, watched only on its third port analog mode output
  pcfg_top #(.BIG_PKG(1'b0)) i_pcfg_top_small (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_req(i_req), .o_rdata(), .i_third_io_port_pins(pc_pins),
    .i_fourth_io_port_pins(pd_pins), .o_third_io_port_read(), .o_fourth_io_port_read(),
    .o_third_io_port_analog(s_an), .o_fourth_io_port_analog(), .i_rp_pins(rp_pins),
    .o_periph_in(), .i_periph_out(p_out), .o_rp_out(), .o_rp_out_en(),
    .o_pin_config_lock());

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(logic [15:0] g, logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [15:0] ex(int a);
    if (a == 0) return mem[0] & ANA_C_MASK;
    if (a == 1) return (mem[1] & ANA_D_MASK) | ANA_D_RSVD;
    if (a == 2) return mem[2] & 16'h0040;
    if ((a >= 16 && a < 40) || (a >= 48 && a < 64)) return mem[a] & IN_MASK;
    return 16'h0000;
  endfunction

  function automatic logic ib(logic [5:0] s);
    return (s < 48) ? rp_pins[s] : 1'b0;
  endfunction

  function automatic logic [1:0] ob(logic [5:0] n);
    return (n != 0 && n < 32) ? {1'b1, p_out[n[4:0]]} : 2'b00;
  endfunction

  task automatic wt(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(int a, logic [15:0] d);
    @(posedge i_mclk);
    i_req.wr <= 1'b1;
    i_req.addr <= a[6:0];
    i_req.wdata <= d;
    @(posedge i_mclk);
    i_req.wr <= 1'b0;
    if (!(mem[2][LOCK_POS] && a >= 16 && a < 64)) mem[a] = d;
  endtask

  // Write then read the same index on back-to-back strobes
  task automatic wrd(int a, logic [15:0] d);
    @(posedge i_mclk);
    i_req.wr <= 1'b1;
    i_req.addr <= a[6:0];
    i_req.wdata <= d;
    @(posedge i_mclk);
    i_req.wr <= 1'b0;
    i_req.rd <= 1'b1;
    if (!(mem[2][LOCK_POS] && a >= 16 && a < 64)) mem[a] = d;
    @(posedge i_mclk);
    i_req.rd <= 1'b0;
    #1;
    chk(o_rdata, ex(a));
  endtask

  task automatic rd(int a);
    @(posedge i_mclk);
    i_req.rd <= 1'b1;
    i_req.addr <= a[6:0];
    @(posedge i_mclk);
    i_req.rd <= 1'b0;
    #1;
    chk(o_rdata, ex(a));
  endtask

  task automatic route();
    logic [15:0] v;
    logic [1:0] lo;
    logic [1:0] hi;
    wt(4);
    for (int k = 0; k < 24; k++) begin
      v = mem[16+k];
      chk({14'h0, p_in[2*k+1], p_in[2*k]},
        {14'h0, ib(v[13:8]), ib(v[5:0])});
    end
    for (int k = 0; k < 16; k++) begin
      v = mem[48+k];
      lo = ob(v[5:0]);
      hi = ob(v[13:8]);
      chk({12'h0, rp_en[2*k+:2], rp_out[2*k+:2]},
        {12'h0, hi[1], lo[1], hi[0], lo[0]});
    end
  endtask

  initial begin
    logic [15:0] d;
    for (int a = 0; a < 128; a++) begin
      mem[a] = (a < 2 || (a >= 16 && a < 40)) ? 16'hffff : 16'h0000;
    end
    void'($urandom(78));
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    wt(1);
    chk(pc_an, ANA_C_MASK);
    chk(pd_an, ANA_D_MASK);
    chk(s_an, ANA_C_MASK & ~ANA_C4_BIT);
    for (int a = 0; a < 64; a++) begin
      rd(a);
    end
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom);
      wrd(0, d);
      wr(1, 16'($urandom));
      @(posedge i_mclk);
      pc_pins <= 16'($urandom);
      pd_pins <= 16'($urandom);
      wt(4);
      chk(pc_an, mem[0] & ANA_C_MASK);
      chk(s_an, mem[0] & ANA_C_MASK & ~ANA_C4_BIT);
      chk(pd_an, mem[1] & ANA_D_MASK);
      chk(pc_rd, pc_pins & ~(mem[0] & ANA_C_MASK));
      chk(pd_rd, pd_pins & ~(mem[1] & ANA_D_MASK));
      rd(0);
      rd(1);
    end
    wr(5, 16'hffff);
    rd(5);
    @(posedge i_mclk);
    rp_pins <= {16'($urandom), 32'($urandom)};
    p_out <= 32'($urandom);
    for (int k = 0; k < 40; k++) begin
      wr((k < 24) ? 16 + k : 24 + k, 16'($urandom));
      rd((k < 24) ? 16 + k : 24 + k);
    end
    route();
    wr(2, 16'hffff);
    wt(1);
    chk({15'h0, lock}, 16'h0001);
    rd(2);
    wr(16, ~mem[16]);
    wr(48, ~mem[48]);
    wr(0, 16'h0000);
    rd(16);
    rd(48);
    rd(0);
    route();
    wr(2, 16'h0000);
    wr(16, 16'h0100);
    wr(48, 16'h011f);
    rd(16);
    route();
    conclude();
  end
endmodule
